/* hdl/prc_pkg.sv */
package prc_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [5:0] PRC_IDX_CONTROL = 6'h00;
  localparam logic [5:0] PRC_IDX_SUBLAYER = 6'h17;
  localparam logic [5:0] PRC_IDX_LOOP_BYPASS = 6'h18;
  localparam logic [5:0] PRC_IDX_STRAP_STATUS = 6'h19;

  // Field positions of the control register.
  localparam int PRC_CTRL_RESET_BIT = 15;
  localparam int PRC_CTRL_LOOP_BIT = 14;
  localparam int PRC_CTRL_SPEED_BIT = 13;
  localparam int PRC_CTRL_DUPLEX_BIT = 8;

  // Field positions of the loopback and bypass register.
  localparam int PRC_LBR_CODE_BYPASS_BIT = 14;
  localparam int PRC_LBR_SCR_BYPASS_BIT = 13;
  localparam int PRC_LBR_ALIGN_BYPASS_BIT = 12;
  localparam int PRC_LBR_LS_LOOP_BIT = 11;
  localparam int PRC_LBR_LSEL_HI_BIT = 9;
  localparam int PRC_LBR_LSEL_LO_BIT = 8;

  // Field position of the sublayer configuration register.
  localparam int PRC_SUB_FORCE_CONNECT_BIT = 5;

  // Reset values and writable bits.
  localparam logic [15:0] PRC_CONTROL_RESET = 16'h2000;
  localparam logic [15:0] PRC_LOOP_BYPASS_RESET = 16'h0000;
  localparam logic [15:0] PRC_SUBLAYER_RESET = 16'h0000;
  localparam logic [15:0] PRC_CONTROL_WMASK = 16'h6100;
  localparam logic [15:0] PRC_LOOP_BYPASS_WMASK = 16'h7b00;
  localparam logic [15:0] PRC_SUBLAYER_WMASK = 16'h0020;

  // Loopback select encodings.
  localparam logic [1:0] PRC_LSEL_XCVR = 2'h2;
  localparam logic [1:0] PRC_LSEL_REMOTE = 2'h1;

  // Symbol values.
  localparam logic [4:0] PRC_LINE_IDLE = 5'h1f;
  localparam logic [4:0] PRC_MII_IDLE = 5'h00;

  // Timing.
  localparam int PRC_CLK_PERIOD_NS = 10;
  localparam int PRC_STRAP_DEADLINE_NS = 2000;
  localparam int PRC_STRAP_DEADLINE_CYCLES =
    PRC_STRAP_DEADLINE_NS / PRC_CLK_PERIOD_NS;
  localparam logic [7:0] PRC_STRAP_SETTLE_CYCLES =
    8'(PRC_STRAP_DEADLINE_CYCLES / 16);
  localparam int PRC_RESYNC_NS = 330000;
  localparam int PRC_RESYNC_CYCLES = PRC_RESYNC_NS / PRC_CLK_PERIOD_NS;
  localparam logic [4:0] PRC_SW_RESET_CYCLES = 5'h10;

  typedef struct packed {
    logic [4:0] mgmtAddr;
    logic negModeStrap1;
    logic negModeStrap0;
    logic repeater;
    logic serialLowSpeedStrap;
    logic alignBypassStrap;
    logic codeBypassStrap;
    logic scramblerBypassStrap;
  } prc_straps_t;

  typedef struct packed {
    logic en;
    logic er;
    logic [3:0] d;
  } prc_mii_tx_t;

  typedef struct packed {
    logic crs;
    logic dv;
    logic er;
    logic [3:0] d;
  } prc_mii_rx_t;

  typedef struct packed {
    logic valid;
    logic carrier;
    logic [4:0] sym;
  } prc_line_t;

  function automatic logic [4:0] prcEncode(input logic [3:0] nib);
    logic [4:0] code;
    code = 5'h00;
    case (nib)
      4'h0: code = 5'h1e;
      4'h1: code = 5'h09;
      4'h2: code = 5'h14;
      4'h3: code = 5'h15;
      4'h4: code = 5'h0a;
      4'h5: code = 5'h0b;
      4'h6: code = 5'h0e;
      4'h7: code = 5'h0f;
      4'h8: code = 5'h12;
      4'h9: code = 5'h13;
      4'ha: code = 5'h16;
      4'hb: code = 5'h17;
      4'hc: code = 5'h1a;
      4'hd: code = 5'h1b;
      4'he: code = 5'h1c;
      default: code = 5'h1d;
    endcase
    return code;
  endfunction : prcEncode

  // Returns {invalid, nibble}; an unknown code yields invalid high.
  function automatic logic [4:0] prcDecode(input logic [4:0] code);
    logic [4:0] res;
    res = 5'h10;
    for (int i = 0; i < 16; i++) begin
      if (prcEncode(4'(i)) == code) begin
        res = {1'b0, 4'(i)};
      end
    end
    return res;
  endfunction : prcDecode

endpackage : prc_pkg

/* hdl/prc_ctrl.sv */
// Function
// - Straps are captured within 2 us of reset pin release.
// - Reset samples address, negotiation, repeater and bypass straps.
// - During power-up reset indicators float and low-speed indicator asserts.
// - Hardware reset pulse restores register defaults and recaptures straps.
// - Control bit 15 starts software reset, reads one, then self-clears.
// - Software reset restores defaults only, straps are kept.
// - At 10 Mb/s either loopback bit loops MII and silences line.
// - At 100 Mb/s control bit 14 loops MII at nibble rate.
// - Select field: 00 normal, bit 9 transceiver, bit 8 remote.
// - Transceiver loopback asserts the loopback-enable output.
// - Remote loopback returns received serial symbols to transmit.
// - Non-remote 100 Mb/s loopback blanks receive valid for 330 us.
// - Transparent mode bypasses 4B/5B by strap or bit 14.
// - Transparent symbol MSB rides on receive and transmit error lines.
// - Transparent mode passes delimiters untouched; controller supplies them.
// - Transparent receive valid unchanged; idles cross MII as zero.
// - Repeater mode suppresses carrier sense during own transmission; here only at 100 Mb/s.
// - Phaser mode by strap or bit 12 passes raw 5-bit words.
// - Fiber mode by strap or bit 13 bypasses the scrambler.
// - Reset pin or software reset request enters reset.
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/10ps
module prc_ctrl import prc_pkg::*; #(
  parameter int RESYNC_CYCLES = PRC_RESYNC_CYCLES
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic resetPin,
  input wire prc_straps_t strapPins,
  input wire logic linkClk,
  input wire prc_mii_tx_t miiTx,
  output prc_mii_rx_t miiRx,
  input wire prc_line_t lineRx,
  output prc_line_t lineTx,
  output logic lineOutEnable,
  output logic xcvrLoopbackOut,
  output logic lowSpeedInd,
  output logic [4:0] indicatorLevels,
  output logic indicatorOe,
  output logic speed100,
  output logic scramblerBypass,
  output logic disconnectBypass,
  output logic serialLowSpeed,
  output logic [4:0] mgmtAddr
);

  logic [1:0] pinSync;
  prc_straps_t strapMeta;
  prc_straps_t strapSync;
  prc_straps_t straps;
  logic strapPending;
  logic [7:0] strapWait;
  logic [15:0] controlReg;
  logic [15:0] loopBypassReg;
  logic [15:0] sublayerReg;
  logic [4:0] swCount;
  logic [2:0] linkSync;
  prc_mii_tx_t txMeta;
  prc_mii_tx_t txSync;
  prc_line_t rxMeta;
  prc_line_t rxSync;
  logic loopArmedPrev;
  logic [15:0] resyncCount;
  prc_mii_rx_t next_miiRx;
  prc_line_t next_lineTx;

  // The reset pin is asynchronous to ref_clk and is synchronised first.
  wire hwReset = pinSync[1];
  wire inReset = hwReset | strapPending;
  wire swBusy = (swCount != 5'h00);
  wire nibbleTick = linkSync[1] & ~linkSync[2];

  // Register bus decode.
  wire [5:0] regIdx = paddr[7:2];
  wire hitControl = (regIdx == PRC_IDX_CONTROL);
  wire hitSublayer = (regIdx == PRC_IDX_SUBLAYER);
  wire hitLoopBypass = (regIdx == PRC_IDX_LOOP_BYPASS);
  wire hitStrap = (regIdx == PRC_IDX_STRAP_STATUS);
  wire regHit = hitControl | hitSublayer | hitLoopBypass | hitStrap;
  wire apbAccess = psel & penable;
  wire apbWrite = apbAccess & pwrite;
  wire wrControl = apbWrite & hitControl;
  wire wrSublayer = apbWrite & hitSublayer;
  wire wrLoopBypass = apbWrite & hitLoopBypass;
  wire swResetReq = wrControl & pwdata[PRC_CTRL_RESET_BIT];
  wire resyncBusy = (resyncCount != 16'h0000);

  wire [15:0] controlRead = {swBusy, controlReg[14:0]};
  wire [15:0] strapRead = {resyncBusy, 2'h0, strapPending, straps};
  wire [15:0] readMux = hitControl ? controlRead :
                        hitSublayer ? sublayerReg :
                        hitLoopBypass ? loopBypassReg :
                        hitStrap ? strapRead : 16'h0000;

  assign pready = apbAccess;
  assign pslverr = apbAccess & ~regHit;

  // Mode decode.
  wire codeBypass = straps.codeBypassStrap |
                    loopBypassReg[PRC_LBR_CODE_BYPASS_BIT];
  wire alignBypass = straps.alignBypassStrap |
                     loopBypassReg[PRC_LBR_ALIGN_BYPASS_BIT];
  wire [1:0] loopSel = {loopBypassReg[PRC_LBR_LSEL_HI_BIT],
                        loopBypassReg[PRC_LBR_LSEL_LO_BIT]};
  wire miiLoop = controlReg[PRC_CTRL_LOOP_BIT] |
                 (~speed100 & loopBypassReg[PRC_LBR_LS_LOOP_BIT]);
  // Value 11 matches neither decode and so runs as normal operation.
  wire xcvrLoop = speed100 & (loopSel == PRC_LSEL_XCVR);
  wire remoteLoop = speed100 & (loopSel == PRC_LSEL_REMOTE);
  wire loopArmed = speed100 & (miiLoop | xcvrLoop);
  // Blank from the arming edge itself, before the counter has been loaded.
  wire resyncStart = loopArmed & ~loopArmedPrev;
  wire rxBlank = resyncStart | resyncBusy;
  wire repeaterQuiet = straps.repeater & speed100 & txSync.en;

  // Transmit symbol selection.
  wire [4:0] txWord = {txSync.er, txSync.d};
  wire [4:0] txTransparent = (txWord == PRC_MII_IDLE) ? PRC_LINE_IDLE :
                             txWord;
  wire [4:0] txCoded = txSync.en ? prcEncode(txSync.d) : PRC_LINE_IDLE;
  wire [4:0] txSym = alignBypass ? txWord :
                     codeBypass ? txTransparent : txCoded;
  wire txValid = txSync.en | alignBypass | codeBypass;

  // Receive symbol selection.
  wire [4:0] rxDecoded = prcDecode(rxSync.sym);
  wire [4:0] rxTransparent = (rxSync.sym == PRC_LINE_IDLE) ? PRC_MII_IDLE :
                             rxSync.sym;
  wire [4:0] rxWord = alignBypass ? rxSync.sym :
                      codeBypass ? rxTransparent : rxDecoded;
  wire rxErr = (alignBypass | codeBypass) ? rxWord[4] :
               (rxWord[4] & rxSync.valid);

  always_comb begin
    next_miiRx.crs = (rxSync.carrier | txSync.en) & ~repeaterQuiet;
    if (miiLoop) begin
      next_miiRx.dv = txSync.en & ~rxBlank;
      next_miiRx.er = txSync.er;
      next_miiRx.d = txSync.d;
    end else begin
      next_miiRx.dv = rxSync.valid & ~rxBlank;
      next_miiRx.er = rxErr;
      next_miiRx.d = rxWord[3:0];
    end
    if (remoteLoop) begin
      next_lineTx = rxSync;
    end else begin
      next_lineTx.valid = txValid & ~miiLoop;
      next_lineTx.carrier = txSync.en & ~miiLoop;
      next_lineTx.sym = txSym;
    end
  end

  assign xcvrLoopbackOut = xcvrLoop;
  assign lineOutEnable = ~miiLoop & ~inReset;
  assign speed100 = controlReg[PRC_CTRL_SPEED_BIT];
  assign lowSpeedInd = inReset | ~speed100;
  assign indicatorOe = ~inReset;
  assign indicatorLevels = {miiRx.crs, miiRx.dv, txSync.en, speed100,
                            controlReg[PRC_CTRL_DUPLEX_BIT]};
  assign scramblerBypass = straps.scramblerBypassStrap |
                           loopBypassReg[PRC_LBR_SCR_BYPASS_BIT];
  assign disconnectBypass = sublayerReg[PRC_SUB_FORCE_CONNECT_BIT];
  assign serialLowSpeed = straps.serialLowSpeedStrap;
  assign mgmtAddr = straps.mgmtAddr;

  // Synchronisers for everything that arrives from outside ref_clk.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pinSync <= 2'h0;
      strapMeta <= '0;
      strapSync <= '0;
      linkSync <= 3'h0;
      txMeta <= '0;
      txSync <= '0;
      rxMeta <= '0;
      rxSync <= '0;
    end else begin
      pinSync <= {pinSync[0], resetPin};
      strapMeta <= strapPins;
      strapSync <= strapMeta;
      linkSync <= {linkSync[1:0], linkClk};
      txMeta <= miiTx;
      txSync <= txMeta;
      rxMeta <= lineRx;
      rxSync <= rxMeta;
    end
  end

  // Straps are taken a short settle time after the pin releases, well
  // inside the capture deadline, so that pins shared with outputs are stable.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      strapPending <= 1'b1;
      strapWait <= 8'h00;
      straps <= '0;
    end else if (hwReset) begin
      strapPending <= 1'b1;
      strapWait <= 8'h00;
    end else if (strapPending) begin
      if (strapWait == PRC_STRAP_SETTLE_CYCLES - 8'h01) begin
        straps <= strapSync;
        strapPending <= 1'b0;
      end else begin
        strapWait <= strapWait + 8'h01;
      end
    end
  end

  // Registers; software reset reloads defaults but leaves straps alone.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      controlReg <= PRC_CONTROL_RESET;
      loopBypassReg <= PRC_LOOP_BYPASS_RESET;
      sublayerReg <= PRC_SUBLAYER_RESET;
      swCount <= 5'h00;
    end else if (hwReset) begin
      controlReg <= PRC_CONTROL_RESET;
      loopBypassReg <= PRC_LOOP_BYPASS_RESET;
      sublayerReg <= PRC_SUBLAYER_RESET;
      swCount <= 5'h00;
    end else if (swBusy) begin
      controlReg <= PRC_CONTROL_RESET;
      loopBypassReg <= PRC_LOOP_BYPASS_RESET;
      sublayerReg <= PRC_SUBLAYER_RESET;
      swCount <= swCount - 5'h01;
    end else if (swResetReq) begin
      swCount <= PRC_SW_RESET_CYCLES;
    end else begin
      if (wrControl) begin
        controlReg <= pwdata[15:0] & PRC_CONTROL_WMASK;
      end
      if (wrLoopBypass) begin
        loopBypassReg <= pwdata[15:0] & PRC_LOOP_BYPASS_WMASK;
      end
      if (wrSublayer) begin
        sublayerReg <= pwdata[15:0] & PRC_SUBLAYER_WMASK;
      end
    end
  end

  // Read data is captured in the setup cycle and shown in the access cycle.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      prdata <= {16'h0000, readMux};
    end
  end

  // Descrambler resynchronisation window after a loopback is armed.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      loopArmedPrev <= 1'b0;
      resyncCount <= 16'h0000;
    end else begin
      loopArmedPrev <= loopArmed;
      if (loopArmed && !loopArmedPrev) begin
        resyncCount <= 16'(RESYNC_CYCLES);
      end else if (resyncBusy) begin
        resyncCount <= resyncCount - 16'h0001;
      end
    end
  end

  // MII and line outputs update on each nibble clock rising edge; receive valid also clears between edges while blanked.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      miiRx <= '0;
      lineTx <= '0;
    end else if (inReset) begin
      miiRx <= '0;
      lineTx <= '0;
    end else if (nibbleTick) begin
      miiRx <= next_miiRx;
      lineTx <= next_lineTx;
    end else if (rxBlank) begin
      // A valid flag latched before arming must not wait for the next tick.
      miiRx.dv <= 1'b0;
    end
  end

endmodule : prc_ctrl

/* verification/prc_ctrl_checker.sv */
`timescale 1ns/10ps
module prc_ctrl_checker import prc_pkg::*; #(
  parameter int RESYNC_CYCLES = PRC_RESYNC_CYCLES
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic resetPin,
  input wire prc_straps_t strapPins,
  input wire prc_mii_rx_t miiRx,
  input wire logic lineOutEnable,
  input wire logic xcvrLoopbackOut,
  input wire logic lowSpeedInd,
  input wire logic indicatorOe,
  input wire logic speed100,
  input wire logic scramblerBypass,
  input wire logic disconnectBypass,
  input wire logic [4:0] mgmtAddr
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence wrReg(logic [5:0] idx);
    psel && penable && pwrite && paddr == {idx, 2'b00};
  endsequence

  chk_xcvr_on: assert property (
    wrReg(PRC_IDX_LOOP_BYPASS) ##0 (pwdata[9:8] == PRC_LSEL_XCVR && speed100)
    |=> xcvrLoopbackOut) else $error("transceiver loopback not raised");
  chk_xcvr_off: assert property (
    wrReg(PRC_IDX_LOOP_BYPASS) ##0 (pwdata[9:8] != PRC_LSEL_XCVR)
    |=> !xcvrLoopbackOut) else $error("transceiver loopback raised");
  chk_sw_keeps_straps: assert property (
    wrReg(PRC_IDX_CONTROL) ##0 pwdata[15] |=> $stable(mgmtAddr)[*8])
    else $error("software reset changed the address");
  chk_hw_defaults: assert property (
    resetPin[*4] |=> speed100 && lowSpeedInd && !indicatorOe
    && !xcvrLoopbackOut && !disconnectBypass)
    else $error("pin reset left a non-default output");
  chk_strap_deadline: assert property (
    $fell(resetPin) |-> ##[1:200] mgmtAddr == strapPins.mgmtAddr)
    else $error("address strap not captured in time");
  chk_loop_line_off: assert property (
    wrReg(PRC_IDX_CONTROL) ##0 (pwdata[14] && !pwdata[15])
    |=> !lineOutEnable) else $error("line driven during loopback");
  chk_resync_blank: assert property (
    wrReg(PRC_IDX_CONTROL) ##0 (pwdata[14] && pwdata[13] && !pwdata[15])
    |=> ##1 (!miiRx.dv)[*8]) else $error("receive valid during resync");
  chk_fiber_bypass: assert property (
    wrReg(PRC_IDX_LOOP_BYPASS) ##0 pwdata[13] |=> scramblerBypass)
    else $error("scrambler bypass not set");
  chk_force_connect: assert property (
    wrReg(PRC_IDX_SUBLAYER) ##0 pwdata[5] |=> disconnectBypass)
    else $error("disconnect bypass not set");
endmodule : prc_ctrl_checker

/* verification/prc_mac_model.sv */
`timescale 1ns/10ps
module prc_mac_model import prc_pkg::*; (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic linkClk,
  input wire prc_mii_tx_t txReq,
  input wire logic txRaw,
  output prc_mii_tx_t miiTx
);
  logic linkPrev;
  wire logic linkRise = linkClk && !linkPrev;
  // Idle data lines flip each nibble so a stale nibble can never pass.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      linkPrev <= 1'b0;
      miiTx <= '0;
    end else begin
      linkPrev <= linkClk;
      if (linkRise && (txReq.en || txRaw)) begin
        miiTx <= txReq;
      end else if (linkRise) begin
        miiTx <= {1'b0, ~miiTx.er, ~miiTx.d};
      end
    end
  end
endmodule : prc_mac_model

/* verification/phy_reset_loopback_bypass_ctrl_tb.sv */
`timescale 1ns/10ps
module phy_reset_loopback_bypass_ctrl_tb import prc_pkg::*;;
  localparam int RESYNC_CYCLES = 50;
  logic ref_clk = 1'b0, resetn = 1'b0, linkClk = 1'b0, resetPin = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, txRaw, e, tr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  prc_straps_t strapPins, straps0;
  prc_mii_tx_t miiTx, txReq;
  prc_mii_rx_t miiRx;
  prc_line_t lineRx, lineTx;
  logic lineOutEnable, xcvrLoopbackOut, lowSpeedInd, indicatorOe, speed100;
  logic scramblerBypass, disconnectBypass, serialLowSpeed;
  logic [4:0] indicatorLevels, mgmtAddr, sym, v;
  logic [7:0] seed = 8'h3a;
  int fails = 0;
  int n_tests = 0;

  always #5 ref_clk = ~ref_clk;
  always #80 linkClk = ~linkClk;

  prc_ctrl #(.RESYNC_CYCLES(RESYNC_CYCLES)) prc_ctrl_inst (.*);
  prc_mac_model prc_mac_model_inst (.ref_clk(ref_clk), .resetn(resetn),
    .linkClk(linkClk), .txReq(txReq), .txRaw(txRaw), .miiTx(miiTx));

  function automatic logic [7:0] lfsrNext(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsrNext
  function automatic logic [4:0] expRx(input logic t, input logic [4:0] s);
    return (t && s == PRC_LINE_IDLE) ? PRC_MII_IDLE : s;
  endfunction : expRx
  function automatic logic [4:0] expTx(input logic t, input logic [4:0] s);
    return (t && s == PRC_MII_IDLE) ? PRC_LINE_IDLE : s;
  endfunction : expTx

  task final_report;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  task apb(input logic w, input logic [5:0] idx, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50) begin
      fails++;
      $display("ERROR pready expected 1 seen 0");
      final_report();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb

  initial begin
    #900000;
    fails++;
    $display("ERROR run expected end seen timeout");
    final_report();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, txRaw} = '0;
    txReq = '0;
    lineRx = '0;
    seed = lfsrNext(seed);
    straps0 = {seed[4:0], seed[7:6], 1'b0, seed[5], 3'b000};
    strapPins = straps0;
    tick(5);
    chk("lowSpeedInd", 1, lowSpeedInd);
    chk("indicatorOe", 0, indicatorOe);
    resetn <= 1'b1;
    tick(200);
    chk("mgmtAddr", straps0.mgmtAddr, mgmtAddr);
    chk("serialLowSpeed", straps0.serialLowSpeedStrap, serialLowSpeed);
    apb(0, PRC_IDX_STRAP_STATUS, 0);
    chk("strapStatus", straps0, q[11:0]);
    apb(0, PRC_IDX_CONTROL, 0);
    chk("control", PRC_CONTROL_RESET, q);
    apb(0, 6'h01, 0);
    chk("pslverr", 1, e);
    $display("test reset done");
    for (int s = 0; s < 4; s++) begin
      apb(1, PRC_IDX_LOOP_BYPASS, 32'(s) << 8);
      seed = lfsrNext(seed);
      lineRx <= {2'b11, seed[4:0]};
      tick(48);
      chk("xcvrLoop", s == 2, xcvrLoopbackOut);
      if (s == 1) chk("lineTx", seed[4:0], lineTx.sym);
    end
    $display("test loopback select done");
    for (int m = 0; m < 4; m++) begin
      tr = (m < 2);
      apb(1, PRC_IDX_LOOP_BYPASS, tr ? 32'h4000 : 32'h1000);
      seed = lfsrNext(seed);
      sym = m[0] ? PRC_LINE_IDLE : seed[4:0];
      v = m[0] ? PRC_MII_IDLE : seed[7:3];
      lineRx <= {2'b11, sym};
      txRaw <= 1'b1;
      txReq <= {1'b1, v};
      tick(48);
      chk("miiRxSym", expRx(tr, sym), {miiRx.er, miiRx.d});
      chk("lineTxSym", expTx(tr, v), lineTx.sym);
    end
    apb(1, PRC_IDX_LOOP_BYPASS, 32'h2000);
    apb(1, PRC_IDX_SUBLAYER, 32'h0020);
    chk("scramblerBypass", 1, scramblerBypass);
    chk("disconnectBypass", 1, disconnectBypass);
    $display("test bypass modes done");
    for (int c = 0; c < 3; c++) begin
      apb(1, PRC_IDX_LOOP_BYPASS, c == 1 ? 32'h0800 : 32'h0000);
      apb(1, PRC_IDX_CONTROL, c == 0 ? 32'h6000 : (c == 1 ? 0 : 32'h4000));
      chk("lineOutEnable", 0, lineOutEnable);
      tick(20);
      if (c == 0) chk("miiRxDv", 0, miiRx.dv);
      tick(80);
      seed = lfsrNext(seed);
      txRaw <= 1'b0;
      txReq <= {2'b10, seed[3:0]};
      tick(48);
      chk("miiRxD", seed[3:0], miiRx.d);
      chk("miiRxDv", 1, miiRx.dv);
      chk("lineTxValid", 0, lineTx.valid);
    end
    $display("test mii loopback done");
    apb(1, PRC_IDX_CONTROL, 32'h2100);
    apb(1, PRC_IDX_LOOP_BYPASS, 32'h1000);
    strapPins.mgmtAddr <= ~straps0.mgmtAddr;
    apb(1, PRC_IDX_CONTROL, 32'h8000);
    apb(0, PRC_IDX_CONTROL, 0);
    chk("swResetBit", 1, q[15]);
    tick(20);
    apb(0, PRC_IDX_CONTROL, 0);
    chk("control", PRC_CONTROL_RESET, q);
    apb(0, PRC_IDX_LOOP_BYPASS, 0);
    chk("loopBypass", PRC_LOOP_BYPASS_RESET, q);
    apb(0, PRC_IDX_SUBLAYER, 0);
    chk("sublayer", PRC_SUBLAYER_RESET, q);
    chk("mgmtAddr", straps0.mgmtAddr, mgmtAddr);
    $display("test software reset done");
    seed = lfsrNext(seed);
    strapPins <= {seed[4:0], 2'b00, 1'b1, 1'b0, 3'b010};
    apb(1, PRC_IDX_LOOP_BYPASS, 32'h0100);
    resetPin <= 1'b1;
    tick(100);
    chk("lowSpeedInd", 1, lowSpeedInd);
    resetPin <= 1'b0;
    tick(200);
    chk("mgmtAddr", seed[4:0], mgmtAddr);
    apb(0, PRC_IDX_LOOP_BYPASS, 0);
    chk("loopBypass", PRC_LOOP_BYPASS_RESET, q);
    lineRx <= {2'b10, PRC_LINE_IDLE};
    txRaw <= 1'b1;
    txReq <= {2'b10, 4'ha};
    tick(48);
    chk("miiRxSym", PRC_MII_IDLE, {miiRx.er, miiRx.d});
    chk("crs", 0, miiRx.crs);
    chk("indicatorLevels", 5'h0e, indicatorLevels);
    $display("test hardware reset done");
    final_report();
  end
endmodule : phy_reset_loopback_bypass_ctrl_tb

bind prc_ctrl prc_ctrl_checker #(.RESYNC_CYCLES(RESYNC_CYCLES))
  prc_ctrl_checker_inst (.*);
